// file: dsu_pkg.sv
// Shared constants for the DDS sweep and update core
`default_nettype none
package dsu_pkg;
  localparam int ACC_W = 32;
  localparam int RATE_W = 16;
  localparam int CORE_DIV = 8;
  localparam int CORE_DIV_W = 3;
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STEP = 8'h04;
  localparam logic [7:0] OFF_RATE = 8'h08;
  localparam logic [7:0] OFF_FTW0 = 8'h0C;
  localparam logic [7:0] OFF_FTW1 = 8'h10;
  localparam logic [7:0] OFF_FTW2 = 8'h14;
  localparam logic [7:0] OFF_FTW3 = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_PHASE = 8'h20;
  localparam logic [7:0] OFF_FREQ = 8'h24;
  localparam logic [7:0] OFF_PROF_RD = 8'h28;
  // Control field positions
  localparam int CTL_AUTOCLR = 0;
  localparam int CTL_REFDIV2 = 1;
  localparam int CTL_PD_LO = 2;
  localparam int CTL_PD_W = 4;
  localparam int CTL_SWEEP_EN = 6;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [3:0] PD_ALL = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// file: dsu_bank_if.sv
// Profile bank connection between the core and its memory
`default_nettype none
interface dsu_bank_if;
  logic we;
  logic [1:0] waddr;
  logic [31:0] wdata;
  logic [1:0] raddr;
  logic [31:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface
`default_nettype wire

// file: dsu_profile_mem.sv
// Four-entry active tuning-word memory with registered read
`default_nettype none
module dsu_profile_mem (
  input wire logic aclk, // clock
  dsu_bank_if.mem bank // bank port
);
  logic [31:0] mem [4];
  always_ff @(posedge aclk)
  begin
    if (bank.we)
      mem[bank.waddr] <= bank.wdata;
    bank.rdata <= mem[bank.raddr];
  end
endmodule
`default_nettype wire

// file: dsu_core.sv
// DDS frequency sweep core with buffered registers and update pins
`default_nettype none
module dsu_core
  import dsu_pkg::*;
(
  input wire logic aclk, // reference clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic update_strobe, // buffer transfer pin
  input wire logic profile_select_low, // profile pin bit 0
  input wire logic profile_select_high, // profile pin bit 1
  input wire logic port_select, // 0 serial, 1 parallel
  output logic core_clock_output, // sample clock over eight
  output logic parallel_mode, // registered port select
  output logic [31:0] phase_out // phase accumulator
);
  // Write buffer
  logic [31:0] buf_ctl, buf_step, buf_ftw0, buf_ftw1, buf_ftw2, buf_ftw3;
  logic [RATE_W-1:0] buf_rate;
  // Active registers
  logic [31:0] act_ctl, act_step;
  logic [RATE_W-1:0] act_rate;
  logic [31:0] freq_acc, phase_acc, cur_ftw;
  logic [RATE_W-1:0] rate_cnt;
  logic half_div;
  logic [CORE_DIV_W-1:0] div_cnt;
  logic [2:0] fud_s, ps0_s, ps1_s, sp_s;
  logic fud_prev;
  logic [1:0] ps_prev;
  logic [1:0] copy_idx;
  logic copying;
  logic fill_done, bank_ok;
  // AXI state
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic rd_pend;
  logic [7:0] ar_addr;

  dsu_bank_if bank ();
  dsu_profile_mem u_mem (
    .aclk(aclk),
    .bank(bank)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // Pin synchronisers: first stage is read only by the second
  wire fud_q = fud_s[1];
  wire [1:0] ps_q = {ps1_s[1], ps0_s[1]};
  wire [1:0] ps_tail = {ps1_s[2], ps0_s[2]};
  wire fud_tail = fud_s[2];

  wire sleep = act_ctl[CTL_PD_LO +: CTL_PD_W] == PD_ALL;
  wire sample_tick = ~sleep & (~act_ctl[CTL_REFDIV2] | half_div);
  wire core_tick = sample_tick &&
    div_cnt == CORE_DIV_W'(CORE_DIV - 1);
  wire core_rise = sample_tick &&
    div_cnt == CORE_DIV_W'(CORE_DIV / 2 - 1);
  // Pins are taken at the rising edge of the core clock output
  wire samp = core_rise;
  wire fud_toggle = samp & (fud_tail != fud_prev);
  wire ps_change = samp & (ps_tail != ps_prev);
  wire do_update = fud_toggle | ps_change;
  wire [1:0] act_prof = ps_prev;

  wire sweep_on = act_ctl[CTL_SWEEP_EN] && act_rate != '0;
  wire step_now = core_tick && sweep_on &&
    rate_cnt == RATE_W'(1);
  wire [31:0] inst_ftw = cur_ftw + freq_acc;

  wire wr_go = aw_hold & w_hold & ~s_axi_bvalid;
  wire [7:0] wa = aw_addr;
  wire wr_ok = wa == OFF_CONTROL || wa == OFF_STEP || wa == OFF_RATE ||
    wa == OFF_FTW0 || wa == OFF_FTW1 || wa == OFF_FTW2 || wa == OFF_FTW3;
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire [31:0] buf_sel = act_prof == 2'd0 ? buf_ftw0 :
    act_prof == 2'd1 ? buf_ftw1 : act_prof == 2'd2 ? buf_ftw2 : buf_ftw3;
  wire [31:0] copy_word = copy_idx == 2'd0 ? buf_ftw0 :
    copy_idx == 2'd1 ? buf_ftw1 : copy_idx == 2'd2 ? buf_ftw2 : buf_ftw3;

  // Copy all four buffered profiles into the bank, one per cycle
  assign bank.we = copying;
  assign bank.waddr = copy_idx;
  assign bank.wdata = copy_word;
  assign bank.raddr = act_prof;

  always_ff @(posedge aclk)
  begin
    // Cleared in reset so no unknown reaches the edge detectors
    fud_s <= aresetn ? {fud_s[1:0], update_strobe} : 3'b000;
    ps0_s <= aresetn ? {ps0_s[1:0], profile_select_low} : 3'b000;
    ps1_s <= aresetn ? {ps1_s[1:0], profile_select_high} : 3'b000;
    sp_s <= aresetn ? {sp_s[1:0], port_select} : 3'b000;
  end

  // Clock generation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      half_div <= 1'b0;
      div_cnt <= '0;
      core_clock_output <= 1'b0;
      parallel_mode <= 1'b0;
    end
    else
    begin
      half_div <= sleep ? 1'b0 : ~half_div;
      parallel_mode <= sp_s[2];
      if (sample_tick)
        div_cnt <= div_cnt + 1'b1;
      if (core_rise)
        core_clock_output <= 1'b1;
      else if (core_tick)
        core_clock_output <= 1'b0;
    end
  end

  // Update capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fud_prev <= 1'b0;
      ps_prev <= 2'b00;
      copying <= 1'b0;
      copy_idx <= 2'd0;
      fill_done <= 1'b0;
      bank_ok <= 1'b0;
      act_ctl <= CTL_RESET;
      act_step <= '0;
      act_rate <= '0;
    end
    else
    begin
      if (samp)
      begin
        fud_prev <= fud_tail;
        ps_prev <= ps_tail;
      end
      if (do_update)
      begin
        act_ctl <= buf_ctl;
        act_step <= buf_step;
        act_rate <= buf_rate;
        copying <= 1'b1;
        copy_idx <= 2'd0;
      end
      else if (copying)
      begin
        copy_idx <= copy_idx + 1'b1;
        copying <= copy_idx != 2'd3;
      end
      // The bank holds unknowns until the first full copy, and the
      // registered read needs one more cycle to catch up
      fill_done <= fill_done | (copying && copy_idx == 2'd3);
      bank_ok <= fill_done;
    end
  end

  // Sweep and phase engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      freq_acc <= '0;
      rate_cnt <= '0;
      phase_acc <= '0;
      cur_ftw <= '0;
      phase_out <= '0;
    end
    else
    begin
      // only the increment changes, phase is kept
      cur_ftw <= bank_ok ? bank.rdata : '0;
      if (sample_tick)
        phase_acc <= phase_acc + inst_ftw;
      phase_out <= phase_acc;
      if (act_ctl[CTL_AUTOCLR])
        freq_acc <= '0;
      else if (step_now)
        freq_acc <= freq_acc + act_step;
      if (!sweep_on)
        rate_cnt <= act_rate;
      else if (core_tick)
        rate_cnt <= (rate_cnt <= RATE_W'(1)) ? act_rate
          : rate_cnt - 1'b1;
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_hold & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Buffer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      buf_ctl <= CTL_RESET;
      buf_step <= '0;
      buf_rate <= '0;
      buf_ftw0 <= '0;
      buf_ftw1 <= '0;
      buf_ftw2 <= '0;
      buf_ftw3 <= '0;
    end
    else if (wr_go)
    begin
      case (wa)
        OFF_CONTROL: buf_ctl <= merge(buf_ctl, w_data, w_strb);
        OFF_STEP: buf_step <= merge(buf_step, w_data, w_strb);
        OFF_RATE: buf_rate <= RATE_W'(merge(32'(buf_rate), w_data, w_strb));
        OFF_FTW0: buf_ftw0 <= merge(buf_ftw0, w_data, w_strb);
        OFF_FTW1: buf_ftw1 <= merge(buf_ftw1, w_data, w_strb);
        OFF_FTW2: buf_ftw2 <= merge(buf_ftw2, w_data, w_strb);
        OFF_FTW3: buf_ftw3 <= merge(buf_ftw3, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      rd_pend <= 1'b0;
      ar_addr <= '0;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~rd_pend & ~s_axi_rvalid;
      if (rd_go)
      begin
        rd_pend <= 1'b1;
        ar_addr <= s_axi_araddr;
      end
      if (rd_pend)
      begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (ar_addr)
          OFF_CONTROL: s_axi_rdata <= buf_ctl;
          OFF_STEP: s_axi_rdata <= buf_step;
          OFF_RATE: s_axi_rdata <= 32'(buf_rate);
          OFF_FTW0: s_axi_rdata <= buf_ftw0;
          OFF_FTW1: s_axi_rdata <= buf_ftw1;
          OFF_FTW2: s_axi_rdata <= buf_ftw2;
          OFF_FTW3: s_axi_rdata <= buf_ftw3;
          OFF_STATUS: s_axi_rdata <= {26'h0, sp_s[2], sleep, ps_q,
            fud_q, sweep_on};
          OFF_PHASE: s_axi_rdata <= phase_acc;
          OFF_FREQ: s_axi_rdata <= inst_ftw;
          OFF_PROF_RD: s_axi_rdata <= buf_sel;
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: dsu_core_props.sv
// Port assertions for the DDS sweep and update core
`default_nettype none
module dsu_core_props
  import dsu_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic port_select, // mode pin
  input wire logic parallel_mode, // mode out
  input wire logic core_clock_output // core clock
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_cco_up;
    !core_clock_output ##1 core_clock_output;
  endsequence
  sequence s_cco_down;
    core_clock_output ##1 !core_clock_output;
  endsequence
  property p_wr_resp;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
  endproperty
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  // Sleep freezes the level, so both halves only ever lengthen
  property p_cco_high;
    s_cco_up |-> core_clock_output [*4];
  endproperty
  property p_cco_low;
    s_cco_down |-> !core_clock_output [*4];
  endproperty
  property p_mode;
    $stable(port_select) [*4] |-> parallel_mode == port_select;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no bvalid");
  a_b_once: assert property (p_b_once) else $error("bvalid repeat");
  a_rd_resp: assert property (p_rd_resp) else $error("no rvalid");
  a_r_once: assert property (p_r_once) else $error("rvalid repeat");
  a_err_zero: assert property (p_err_zero) else $error("err data");
  a_cco_high: assert property (p_cco_high) else $error("cco high");
  a_cco_low: assert property (p_cco_low) else $error("cco low");
  a_mode: assert property (p_mode) else $error("mode pin");
endmodule
bind dsu_core dsu_core_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_select,
  .parallel_mode, .core_clock_output);
`default_nettype wire

// file: dsu_ctl_model.sv
// Controller model driving the update and profile pins on the core clock
`default_nettype none
module dsu_ctl_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic core_clock_output, // core clock from the core
  input wire logic req_update, // one-cycle update request
  input wire logic [1:0] req_profile, // wanted profile
  output logic update_strobe, // update pin
  output logic profile_select_low, // profile pin 0
  output logic profile_select_high // profile pin 1
);
  logic cco_q;
  logic pend;
  wire cco_rise = core_clock_output && !cco_q;
  // Pins move only just after a core clock rise, as external logic would
  always_ff @(posedge aclk)
  begin
    cco_q <= core_clock_output;
    pend <= aresetn && (req_update || (pend && !cco_rise));
    if (!aresetn)
    begin
      update_strobe <= 1'b0;
      {profile_select_high, profile_select_low} <= 2'b00;
    end
    else if (cco_rise)
    begin
      update_strobe <= update_strobe ^ pend;
      {profile_select_high, profile_select_low} <= req_profile;
    end
  end
endmodule
`default_nettype wire

// file: tb_dsu_core.sv
// Self-checking bench for the DDS sweep and update core
`default_nettype none
module tb_dsu_core
  import dsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, req_update, port_select;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, phase_out, f0, v, v2, p;
  logic [1:0] s_axi_bresp, s_axi_rresp, req_profile, rr, br;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, update_strobe, profile_select_low;
  logic profile_select_high, core_clock_output, parallel_mode;
  logic [3:0] s_axi_wstrb;
  int mismatches, n_compared, seed;
  dsu_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .update_strobe,
    .profile_select_low, .profile_select_high, .port_select,
    .core_clock_output, .parallel_mode, .phase_out);
  dsu_ctl_model u_ctl (.aclk, .aresetn, .core_clock_output, .req_update,
    .req_profile, .update_strobe, .profile_select_low,
    .profile_select_high);
  task automatic stop_test();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One when a drift lies between lo and hi whole sweep steps
  function automatic logic [31:0] in_span(input logic [31:0] d,
    input logic [31:0] step, input int lo, input int hi);
    return 32'(d >= step * 32'(lo) && d <= step * 32'(hi));
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic upd(input logic [1:0] pr);
    @(posedge aclk);
    req_update <= 1'b1;
    req_profile <= pr;
    @(posedge aclk);
    req_update <= 1'b0;
  endtask
  // Polls because the copy lands a core clock period or so later
  task automatic wait_f(input logic [31:0] e);
    repeat (30)
    begin
      rd(OFF_FREQ);
      if (v === e) break;
    end
    chk(v, e);
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
  initial
  begin
    seed = 32'h5470;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, req_update, port_select} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_profile} = 50'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    f0 = $random(seed);
    wr(OFF_FTW0, f0);
    rd(OFF_FREQ);
    chk(v, 32'h0);
    upd(2'd0);
    wait_f(f0);
    @(posedge aclk);
    p = phase_out;
    @(posedge aclk);
    chk(phase_out - p, f0);
    wr(OFF_CONTROL, 32'h2);
    upd(2'd0);
    repeat (40) @(posedge aclk);
    p = phase_out;
    repeat (2) @(posedge aclk);
    chk(phase_out - p, f0);
    for (int i = 1; i < 4; i++)
    begin
      v2 = $random(seed);
      wr(OFF_FTW0 + 8'(4 * i), v2);
      upd(2'(i));
      wait_f(v2);
      rd(OFF_PROF_RD);
      chk(v, v2);
    end
    req_profile <= 2'd0;
    wait_f(f0);
    wr(OFF_STEP, 32'h10);
    wr(OFF_RATE, 32'h1);
    wr(OFF_CONTROL, 32'h40);
    upd(2'd0);
    repeat (80) @(posedge aclk);
    rd(OFF_FREQ);
    p = v;
    chk({28'h0, p[3:0] - f0[3:0]}, 32'h0);
    chk(32'($signed(p - f0) > 0), 32'h1);
    repeat (80) @(posedge aclk);
    rd(OFF_FREQ);
    chk(in_span(v - p, 32'h10, 9, 12), 32'h1);
    rd(OFF_PROF_RD);
    chk(v, f0);
    wr(OFF_CONTROL, 32'h41);
    upd(2'd0);
    wait_f(f0);
    wr(OFF_STEP, 32'hFFFF_FFF0);
    wr(OFF_CONTROL, 32'h40);
    upd(2'd0);
    repeat (40) @(posedge aclk);
    rd(OFF_FREQ);
    chk(32'($signed(v - f0) < 0), 32'h1);
    wr(OFF_RATE, 32'h0);
    upd(2'd0);
    repeat (20) @(posedge aclk);
    rd(OFF_FREQ);
    p = v;
    repeat (40) @(posedge aclk);
    rd(OFF_FREQ);
    chk(v, p);
    rd(8'h3C);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(8'h3C, f0);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    // Only byte lane 0 may change the buffered step word
    s_axi_wstrb <= 4'h1;
    wr(OFF_STEP, 32'h1234_56AB);
    s_axi_wstrb <= 4'hF;
    rd(OFF_STEP);
    chk(v, 32'hFFFF_FFAB);
    port_select <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({31'h0, parallel_mode}, 32'h1);
    rd(OFF_STATUS);
    chk(v & 32'hFFFF_FFFD, 32'h20);
    // Sleep last: pins are sampled on the core clock, which then stops
    wr(OFF_CONTROL, 32'h3C);
    upd(2'd0);
    repeat (40) @(posedge aclk);
    p = phase_out;
    repeat (16) @(posedge aclk);
    chk(phase_out, p);
    rd(OFF_PHASE);
    chk(v, p);
    stop_test();
  end
endmodule
`default_nettype wire
